// ==== can_mailbox_filter_status.sv ====
// Mailbox object types, acceptance filtering and per-mailbox status behind Wishbone.
`timescale 1ns/1ps
`default_nettype none

module can_mailbox_filter_status
  import can_mbx_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                resetn,
  // Wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [11:0]         wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // Protocol core: received frames and timing
  input  wire logic                rx_valid_i,
  input  wire logic                rx_ide_i,
  input  wire logic [28:0]         rx_id_i,
  input  wire logic                rx_rtr_i,
  input  wire logic [3:0]          rx_dlc_i,
  input  wire logic                sof_i,
  input  wire logic [15:0]         timer_i,
  // Protocol core: transmit completion
  input  wire logic                tx_done_i,
  input  wire logic [2:0]          tx_mb_i,
  // Mailbox requests towards the core
  output logic      [NUM_MB-1:0]   store_o,
  output logic      [NUM_MB-1:0]   tx_request_o,
  output logic      [NUM_MB-1:0]   tx_remote_o,
  output logic      [NUM_MB-1:0]   ready_irq_o
);

  function automatic logic [31:0] byte_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : byte_merge

  function automatic logic id_match(input logic [31:0] id, input logic [31:0] mask,
                                    input logic ide, input logic [28:0] rid);
    logic [28:0] keep;
    keep = mask[IDE_BIT] ? mask[28:0] : {mask[28:STD_LSB], 18'h00000};
    return (ide == id[IDE_BIT]) && (((id[28:0] ^ rid) & keep) == 29'h0);
  endfunction : id_match

  function automatic logic [31:0] id_view(input logic [31:0] id);
    logic [31:0] r;
    r = id & 32'h3FFF_FFFF;
    if (!id[IDE_BIT]) begin
      r[STD_LSB-1:0] = 18'h00000;
    end
    return r;
  endfunction : id_view

  function automatic logic [31:0] family(input logic [31:0] id, input logic [31:0] mask);
    logic [28:0] r;
    logic [4:0]  k;
    r = 29'h0;
    k = 5'h0;
    for (int i = 0; i < 29; i++) begin
      if (mask[i]) begin
        r[k] = id[i];
        k    = k + 5'h1;
      end
    end
    return {3'h0, r};
  endfunction : family

  function automatic logic is_active(input logic [2:0] t);
    return (t != OT_DISABLED) && (t[2:1] != 2'b11);
  endfunction : is_active

  // Bus decode.
  logic            acc;
  logic            in_mb;
  logic [2:0]      mb_sel;
  logic [4:0]      reg_sel;
  logic [NUM_MB-1:0] mode_wr, cmd_wr, stat_rd, mask_wr, id_wr;
  logic            ctrl_wr;
  logic [NUM_MB-1:0] hit;

  assign acc     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign in_mb   = (wb_adr_i[11:8] == MB_REGION);
  assign mb_sel  = wb_adr_i[7:5];
  assign reg_sel = {wb_adr_i[4:2], 2'b00};
  assign ctrl_wr = acc && wb_we_i && (wb_adr_i == CONTROLLER_MODE_OFS);

  always_comb begin
    for (int m = 0; m < NUM_MB; m++) begin
      mode_wr[m] = acc && wb_we_i && in_mb && (mb_sel == m[2:0]) && (reg_sel == MODE_OFS);
      mask_wr[m] = acc && wb_we_i && in_mb && (mb_sel == m[2:0]) && (reg_sel == ACCEPT_MASK_OFS);
      id_wr[m]   = acc && wb_we_i && in_mb && (mb_sel == m[2:0]) && (reg_sel == IDENTIFIER_OFS);
      cmd_wr[m]  = acc && wb_we_i && in_mb && (mb_sel == m[2:0]) && (reg_sel == CONTROL_OFS);
      stat_rd[m] = acc && !wb_we_i && in_mb && (mb_sel == m[2:0]) && (reg_sel == STATUS_OFS);
    end
  end

  // Register state.
  logic [31:0] ctrl_mode_q, ctrl_mode_d;
  logic [NUM_MB-1:0][2:0]  type_q, type_d;
  logic [NUM_MB-1:0][31:0] mask_q, mask_d, id_q, id_d;
  logic [NUM_MB-1:0]       ready_q, ready_d, abort_q, abort_d, ign_q, ign_d, rtr_q, rtr_d;
  logic [NUM_MB-1:0]       txreq_q, txreq_d, armed_q, armed_d, store_d, irq_d, remote_d;
  logic [NUM_MB-1:0][3:0]  dlc_q, dlc_d;
  logic [NUM_MB-1:0][15:0] stamp_q, stamp_d;
  logic [15:0] sof_stamp_q, sof_stamp_d, stamp_now;
  logic        tt_on;
  logic [31:0] rdat_d;
  logic        ack_d;

  assign tt_on = ctrl_mode_q[TT_ENABLE_BIT];

  always_comb begin
    ctrl_mode_d = ctrl_wr ? byte_merge(ctrl_mode_q, wb_dat_i, wb_sel_i) : ctrl_mode_q;
    sof_stamp_d = sof_i ? timer_i : sof_stamp_q;
    stamp_now   = ctrl_mode_q[STAMP_END_BIT] ? timer_i : sof_stamp_q;
    type_d  = type_q;
    mask_d  = mask_q;
    id_d    = id_q;
    ready_d = ready_q;
    abort_d = abort_q;
    ign_d   = ign_q;
    rtr_d   = rtr_q;
    txreq_d = txreq_q;
    armed_d = armed_q;
    dlc_d   = dlc_q;
    stamp_d = stamp_q;
    store_d = '0;
    hit     = '0;
    for (int m = 0; m < NUM_MB; m++) begin
      logic upd;
      upd = 1'b0;
      hit[m] = rx_valid_i && is_active(type_q[m]) && id_match(id_q[m], mask_q[m], rx_ide_i, rx_id_i);
      if (mask_wr[m]) begin
        mask_d[m] = byte_merge(mask_q[m], wb_dat_i, wb_sel_i);
      end
      if (id_wr[m]) begin
        id_d[m] = byte_merge(id_q[m], wb_dat_i, wb_sel_i);
      end
      // Commands first so that a same-cycle hardware event wins.
      if (stat_rd[m]) begin
        ign_d[m] = 1'b0;
      end
      if (cmd_wr[m] && (wb_dat_i[XFER_CMD_BIT] || wb_dat_i[ABORT_CMD_BIT])) begin
        ready_d[m] = 1'b0;
        abort_d[m] = 1'b0;
      end
      if (cmd_wr[m] && wb_dat_i[XFER_CMD_BIT]) begin
        case (type_q[m])
          OT_TRANSMIT: txreq_d[m] = 1'b1;
          OT_CONSUMER: begin
            txreq_d[m] = 1'b1;
            armed_d[m] = 1'b0;
          end
          OT_PRODUCER: begin
            armed_d[m] = 1'b1;
            dlc_d[m]   = wb_dat_i[DLC_LSB +: 4];
          end
          default: ;
        endcase
      end
      if (cmd_wr[m] && wb_dat_i[ABORT_CMD_BIT] && (txreq_q[m] || armed_q[m])) begin
        txreq_d[m] = 1'b0;
        armed_d[m] = 1'b0;
        abort_d[m] = 1'b1;
        upd        = 1'b1;
      end
      // Received frame for this mailbox.
      if (hit[m]) begin
        case (type_q[m])
          OT_RECEIVE: begin
            if (ready_q[m]) begin
              ign_d[m] = 1'b1;
            end else begin
              store_d[m] = 1'b1;
              ready_d[m] = 1'b1;
              dlc_d[m]   = rx_dlc_i;
              rtr_d[m]   = rx_rtr_i;
              upd        = 1'b1;
            end
          end
          OT_RX_OVERWRITE: begin
            ign_d[m]   = ign_q[m] || ready_q[m];
            store_d[m] = 1'b1;
            ready_d[m] = 1'b1;
            dlc_d[m]   = rx_dlc_i;
            rtr_d[m]   = rx_rtr_i;
            upd        = 1'b1;
          end
          OT_CONSUMER: begin
            // Data is taken only once this mailbox's own remote frame has gone out.
            if (!rx_rtr_i && armed_q[m]) begin
              if (ready_q[m]) begin
                ign_d[m] = 1'b1;
              end else begin
                store_d[m] = 1'b1;
                ready_d[m] = 1'b1;
                dlc_d[m]   = rx_dlc_i;
                upd        = 1'b1;
              end
            end
          end
          OT_PRODUCER: begin
            if (rx_rtr_i) begin
              if (armed_q[m]) begin
                armed_d[m] = 1'b0;
                txreq_d[m] = 1'b1;
              end else begin
                ign_d[m] = 1'b1;
              end
            end
          end
          default: ;
        endcase
      end
      // Transmission finished by the core.
      if (tx_done_i && (tx_mb_i == m[2:0]) && txreq_q[m]) begin
        txreq_d[m] = 1'b0;
        if (type_q[m] != OT_CONSUMER) begin
          ready_d[m] = 1'b1;
          upd        = 1'b1;
        end else begin
          armed_d[m] = 1'b1;
        end
      end
      if (upd) begin
        stamp_d[m] = stamp_now;
      end
      if (tt_on) begin
        stamp_d[m] = 16'h0000;
      end
      // Reconfiguration resets the handshake state of the mailbox.
      if (mode_wr[m] && wb_sel_i[OBJ_TYPE_LSB/8]) begin
        type_d[m]  = wb_dat_i[OBJ_TYPE_LSB +: 3];
        txreq_d[m] = 1'b0;
        armed_d[m] = 1'b0;
        abort_d[m] = 1'b0;
        ign_d[m]   = 1'b0;
        ready_d[m] = (wb_dat_i[OBJ_TYPE_LSB +: 3] == OT_TRANSMIT) ||
                     (wb_dat_i[OBJ_TYPE_LSB +: 3] == OT_PRODUCER);
        if (wb_dat_i[OBJ_TYPE_LSB +: 3] == OT_CONSUMER) begin
          rtr_d[m] = 1'b1;
        end else if (wb_dat_i[OBJ_TYPE_LSB +: 3] == OT_PRODUCER) begin
          rtr_d[m] = 1'b0;
        end
      end
      if (!is_active(type_d[m])) begin
        txreq_d[m] = 1'b0;
      end
      irq_d[m]    = ready_d[m] && !ready_q[m];
      remote_d[m] = (type_d[m] == OT_CONSUMER);
    end
  end

  // Bus answer: one cycle after the request, unmapped reads return zero.
  always_comb begin
    ack_d  = acc;
    rdat_d = 32'h0000_0000;
    if (acc && !wb_we_i) begin
      if (wb_adr_i == CONTROLLER_MODE_OFS) begin
        rdat_d = ctrl_mode_q & 32'h0000_0003;
      end else if (in_mb) begin
        case (reg_sel)
          MODE_OFS:        rdat_d = {5'h00, type_q[mb_sel], 24'h000000};
          ACCEPT_MASK_OFS: rdat_d = mask_q[mb_sel] & 32'h3FFF_FFFF;
          IDENTIFIER_OFS:  rdat_d = id_view(id_q[mb_sel]);
          FAMILY_OFS:      rdat_d = family(id_view(id_q[mb_sel]), mask_q[mb_sel]);
          STATUS_OFS:      rdat_d = {7'h00, ign_q[mb_sel], ready_q[mb_sel], abort_q[mb_sel],
                                     1'b0, rtr_q[mb_sel], dlc_q[mb_sel], stamp_q[mb_sel]};
          default:         rdat_d = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_mode_q  <= REG_RESET;
      sof_stamp_q  <= 16'h0000;
      type_q       <= '0;
      mask_q       <= '0;
      id_q         <= '0;
      ready_q      <= '0;
      abort_q      <= '0;
      ign_q        <= '0;
      rtr_q        <= '0;
      txreq_q      <= '0;
      armed_q      <= '0;
      dlc_q        <= '0;
      stamp_q      <= '0;
      store_o      <= '0;
      tx_remote_o  <= '0;
      ready_irq_o  <= '0;
      wb_ack_o     <= 1'b0;
      wb_dat_o     <= 32'h0000_0000;
    end else begin
      ctrl_mode_q  <= ctrl_mode_d;
      sof_stamp_q  <= sof_stamp_d;
      type_q       <= type_d;
      mask_q       <= mask_d;
      id_q         <= id_d;
      ready_q      <= ready_d;
      abort_q      <= abort_d;
      ign_q        <= ign_d;
      rtr_q        <= rtr_d;
      txreq_q      <= txreq_d;
      armed_q      <= armed_d;
      dlc_q        <= dlc_d;
      stamp_q      <= stamp_d;
      store_o      <= store_d;
      tx_remote_o  <= remote_d;
      ready_irq_o  <= irq_d;
      wb_ack_o     <= ack_d;
      wb_dat_o     <= rdat_d;
    end
  end

  assign tx_request_o = txreq_q;

  // Checks on mailbox behaviour.
  for (genvar g = 0; g < NUM_MB; g++) begin : g_chk
    property p_off_quiet;
      @(posedge clk) disable iff (!resetn)
        !is_active(type_q[g]) |=> !store_o[g] && !tx_request_o[g];
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("inactive mailbox acted");

    property p_rx_discard;
      @(posedge clk) disable iff (!resetn)
        hit[g] && type_q[g] == OT_RECEIVE && ready_q[g] |=> !store_o[g] && ign_q[g];
    endproperty
    a_rx_discard: assert property (p_rx_discard) else $error("full mailbox stored");

    property p_rx_over;
      @(posedge clk) disable iff (!resetn)
        hit[g] && type_q[g] == OT_RX_OVERWRITE && !mode_wr[g] |=> store_o[g] && ready_q[g];
    endproperty
    a_rx_over: assert property (p_rx_over) else $error("overwrite not stored");

    property p_prod_send;
      @(posedge clk) disable iff (!resetn)
        hit[g] && rx_rtr_i && type_q[g] == OT_PRODUCER && armed_q[g] && !mode_wr[g]
          && !cmd_wr[g] |=> tx_request_o[g];
    endproperty
    a_prod_send: assert property (p_prod_send) else $error("producer did not answer");

    property p_cons_wait;
      @(posedge clk) disable iff (!resetn)
        hit[g] && type_q[g] == OT_CONSUMER && !armed_q[g] |=> !store_o[g];
    endproperty
    a_cons_wait: assert property (p_cons_wait) else $error("consumer stored early");

    property p_read_clear;
      @(posedge clk) disable iff (!resetn)
        stat_rd[g] && !rx_valid_i && !mode_wr[g] |=> !ign_q[g];
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("ignored flag kept");

    property p_cmd_clear;
      @(posedge clk) disable iff (!resetn)
        cmd_wr[g] && wb_dat_i[XFER_CMD_BIT] && !wb_dat_i[ABORT_CMD_BIT] |=> !abort_q[g];
    endproperty
    a_cmd_clear: assert property (p_cmd_clear) else $error("abort flag kept");

    property p_tt_zero;
      @(posedge clk) disable iff (!resetn)
        tt_on |=> stamp_q[g] == 16'h0000;
    endproperty
    a_tt_zero: assert property (p_tt_zero) else $error("stamp not zero");

    property p_cons_rtr;
      @(posedge clk) disable iff (!resetn)
        mode_wr[g] && wb_sel_i[3] && wb_dat_i[26:24] == OT_CONSUMER |=> rtr_q[g] ##1 tx_remote_o[g];
    endproperty
    a_cons_rtr: assert property (p_cons_rtr) else $error("consumer remote flag");

    property p_irq;
      @(posedge clk) disable iff (!resetn)
        $rose(ready_q[g]) |-> ready_irq_o[g] ##1 !ready_irq_o[g];
    endproperty
    a_irq: assert property (p_irq) else $error("ready interrupt missing");
  end

  property p_ack;
    @(posedge clk) disable iff (!resetn)
      acc |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer timing");

  c_store: cover property (@(posedge clk) disable iff (!resetn) |store_o);
  c_ignored: cover property (@(posedge clk) disable iff (!resetn) |ign_q);
  c_abort: cover property (@(posedge clk) disable iff (!resetn) |abort_q);
  c_prod: cover property (@(posedge clk) disable iff (!resetn) |(tx_request_o & ~tx_remote_o));

endmodule : can_mailbox_filter_status
`default_nettype wire

// ==== can_mbx_pkg.sv ====
// Constants, register map and types for the mailbox filter and status block.
`default_nettype none
package can_mbx_pkg;
  localparam int NUM_MB = 8;

  // Word-aligned byte offsets, and the region number of the mailbox block.
  localparam logic [11:0] CONTROLLER_MODE_OFS = 12'h000;
  localparam logic [3:0]  MB_REGION           = 4'h2;
  localparam logic [4:0]  MODE_OFS            = 5'h00;
  localparam logic [4:0]  ACCEPT_MASK_OFS     = 5'h04;
  localparam logic [4:0]  IDENTIFIER_OFS      = 5'h08;
  localparam logic [4:0]  FAMILY_OFS          = 5'h0C;
  localparam logic [4:0]  STATUS_OFS          = 5'h10;
  localparam logic [4:0]  CONTROL_OFS         = 5'h1C;

  // Field positions.
  localparam int OBJ_TYPE_LSB    = 24;
  localparam int IDE_BIT         = 29;
  localparam int STD_LSB         = 18;
  localparam int IGNORED_BIT     = 24;
  localparam int READY_BIT       = 23;
  localparam int ABORT_BIT       = 22;
  localparam int REMOTE_BIT      = 20;
  localparam int DLC_LSB         = 16;
  localparam int XFER_CMD_BIT    = 23;
  localparam int ABORT_CMD_BIT   = 22;
  localparam int TT_ENABLE_BIT   = 0;
  localparam int STAMP_END_BIT   = 1;

  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  typedef enum logic [2:0] {
    OT_DISABLED     = 3'h0,
    OT_RECEIVE      = 3'h1,
    OT_RX_OVERWRITE = 3'h2,
    OT_TRANSMIT     = 3'h3,
    OT_CONSUMER     = 3'h4,
    OT_PRODUCER     = 3'h5
  } object_type_e;
endpackage : can_mbx_pkg
`default_nettype wire

// ==== can_core_model.sv ====
// Behavioural protocol core that delivers frames and completes transmissions.
`timescale 1ns/1ps
`default_nettype none
module can_core_model (
  // Clock and mailbox requests
  input  wire logic [7:0] tx_req,
  input  wire logic       clk,
  // Frames, timing and completion
  output logic            rx_valid,
  output logic            rx_ide,
  output logic [28:0]     rx_id,
  output logic            rx_rtr,
  output logic [3:0]      rx_dlc,
  output logic            sof,
  output logic [15:0]     timer,
  output logic            tx_done,
  output logic [2:0]      tx_mb
);
  int dly = 3;
  initial begin
    {rx_valid, rx_ide, rx_id, rx_rtr, rx_dlc, sof, timer, tx_done, tx_mb} = '0;
  end
  task automatic send(input logic ide, input logic [28:0] id, input logic rtr,
                      input logic [3:0] dlc, input logic [15:0] ts, input logic [15:0] te);
    @(posedge clk);
    {sof, timer} <= {1'b1, ts};
    @(posedge clk);
    {sof, timer, rx_ide, rx_id, rx_rtr, rx_dlc} <= {1'b0, te, ide, id, rtr, dlc};
    @(posedge clk);
    rx_valid <= 1'b1;
    @(posedge clk);
    // Released fields show the inverse so that a stale frame cannot match by luck.
    {rx_valid, rx_ide, rx_id, rx_rtr, rx_dlc} <= {1'b0, ~ide, ~id, ~rtr, ~dlc};
  endtask : send
  // The lowest pending mailbox is served first; a request withdrawn meanwhile is skipped.
  initial begin : serve
    int m;
    forever begin
      @(posedge clk);
      m = -1;
      for (int i = 7; i >= 0; i--) if (tx_req[i] === 1'b1) m = i;
      if (m >= 0) begin
        repeat (dly) @(posedge clk);
        if (tx_req[m] === 1'b1) begin
          {tx_done, tx_mb} <= {1'b1, 3'(m)};
          @(posedge clk);
          {tx_done, tx_mb} <= {1'b0, ~3'(m)};
        end
      end
    end
  end
endmodule : can_core_model
`default_nettype wire

// ==== tb_can_mailbox_filter_status.sv ====
// Self-checking bench for the mailbox filter and status block.
`timescale 1ns/1ps
`default_nettype none
module tb_can_mailbox_filter_status
  import can_mbx_pkg::*;
;
  logic              clk = 1'b0, resetn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [11:0]       adr = '0;
  logic [3:0]        sel = '0;
  logic [31:0]       wdat = '0, rdat, q, idv, mk;
  logic              ack, rxv, rxide, rxrtr, sof, txd;
  logic [28:0]       rxid;
  logic [3:0]        rxdlc, dl[8];
  logic [15:0]       timer, ts[8], te[8];
  logic [2:0]        txmb;
  logic [NUM_MB-1:0] sto, txr, txo, irq;
  int                n_errors = 0, checks_done = 0, seed = 84, n_store[8], n_irq[8];
  int                exp_store[8] = '{0, 3, 0, 2, 1, 0, 0, 0};
  int                exp_irq[8] = '{0, 3, 2, 1, 1, 2, 0, 0};

  can_mailbox_filter_status i_dut (
    .clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .rx_valid_i(rxv), .rx_ide_i(rxide), .rx_id_i(rxid), .rx_rtr_i(rxrtr), .rx_dlc_i(rxdlc),
    .sof_i(sof), .timer_i(timer), .tx_done_i(txd), .tx_mb_i(txmb),
    .store_o(sto), .tx_request_o(txr), .tx_remote_o(txo), .ready_irq_o(irq)
  );
  can_core_model i_core (
    .clk(clk), .tx_req(txr), .rx_valid(rxv), .rx_ide(rxide), .rx_id(rxid), .rx_rtr(rxrtr),
    .rx_dlc(rxdlc), .sof(sof), .timer(timer), .tx_done(txd), .tx_mb(txmb)
  );

  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    for (int i = 0; i < NUM_MB; i++) begin
      if (sto[i] === 1'b1) n_store[i]++;
      if (irq[i] === 1'b1) n_irq[i]++;
    end
  end

  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  initial begin
    #500000;
    n_errors++;
    test_done();
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m,
                     input string w);
    checks_done++;
    if ((g & m) !== (e & m)) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, w, g, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hF};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    {cyc, stb} <= 2'b00;
    q = rdat;
    if (n >= 20) chk(32'h0, 32'h1, 32'h1, "bus answer");
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
                    input string w);
    bus(1'b0, a, 32'h0);
    chk(q, e, m, w);
  endtask : rd
  task automatic fr(input logic i, input logic [28:0] id, input logic r, input int k);
    i_core.send(i, id, r, dl[k], ts[k], te[k]);
    repeat (2) @(posedge clk);
  endtask : fr
  task automatic settle(input int m);
    for (int n = 0; n < 100 && txr[m] !== 1'b0; n++) @(posedge clk);
  endtask : settle
  function automatic logic [11:0] ma(input int m, input logic [4:0] o);
    return {MB_REGION, 3'(m), o};
  endfunction : ma
  // Flags are ignored, ready, abort, remote from the top down.
  function automatic logic [31:0] st(input logic [3:0] f, input int k, input logic [15:0] s);
    return {7'h00, f[3:1], 1'b0, f[0], dl[k], s};
  endfunction : st
  // Extended bits count as zero when the identifier is in standard format.
  function automatic logic [31:0] fam(input logic [31:0] id, input logic [31:0] m);
    logic [31:0] r;
    int          k;
    r = '0;
    k = 0;
    if (id[29] == 1'b0) id[17:0] = '0;
    for (int i = 0; i < 29; i++) if (m[i]) r[k++] = id[i];
    return r;
  endfunction : fam

  initial begin : main
    for (int k = 0; k < 8; k++) begin
      {ts[k], te[k]} = 32'($random(seed));
      dl[k] = 4'($random(seed));
    end
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    rd(ma(1, STATUS_OFS), REG_RESET, '1, "status reset");
    rd(ma(1, MODE_OFS), REG_RESET, '1, "mode reset");
    wr(12'h100, 32'hFFFFFFFF);
    rd(12'h100, 32'h0, '1, "unmapped");
    for (int k = 0; k < 4; k++) begin
      idv = {2'b00, k[0], 29'($random(seed))};
      mk = {3'b001, 29'($random(seed))};
      wr(ma(0, ACCEPT_MASK_OFS), mk);
      wr(ma(0, IDENTIFIER_OFS), idv);
      wr(ma(0, FAMILY_OFS), 32'hFFFFFFFF);
      rd(ma(0, ACCEPT_MASK_OFS), mk, '1, "mask");
      rd(ma(0, IDENTIFIER_OFS), k[0] ? idv : idv & 32'hFFFC0000, '1, "ident");
      rd(ma(0, FAMILY_OFS), fam(idv, mk), '1, "family");
    end
    // Mailboxes 6 and 7 keep a zero mask, so only their type keeps standard frames out.
    wr(ma(7, MODE_OFS), 32'h06000000);
    wr(ma(1, ACCEPT_MASK_OFS), 32'h1FFC0000);
    wr(ma(1, IDENTIFIER_OFS), 32'h048C0000);
    wr(ma(1, MODE_OFS), 32'h01000000);
    fr(1'b0, {11'h123, 18'h2AAAA}, 1'b1, 0);
    rd(ma(1, STATUS_OFS), st(4'b0101, 0, ts[0]), '1, "first rx");
    fr(1'b0, {11'h123, 18'h15555}, 1'b0, 1);
    fr(1'b0, {11'h124, 18'h0}, 1'b0, 2);
    rd(ma(1, STATUS_OFS), st(4'b1101, 0, ts[0]), '1, "ignored");
    rd(ma(1, STATUS_OFS), st(4'b0101, 0, ts[0]), '1, "read clear");
    wr(ma(1, CONTROL_OFS), 32'h00800000);
    rd(ma(1, STATUS_OFS), st(4'b0001, 0, ts[0]), '1, "ready clear");
    wr(CONTROLLER_MODE_OFS, 32'h1);
    fr(1'b0, {11'h123, 18'h0}, 1'b0, 3);
    rd(ma(1, STATUS_OFS), st(4'b0100, 3, 16'h0), '1, "tt stamp");
    wr(ma(1, CONTROL_OFS), 32'h00800000);
    wr(CONTROLLER_MODE_OFS, 32'h2);
    fr(1'b0, {11'h123, 18'h3}, 1'b1, 4);
    rd(ma(1, STATUS_OFS), st(4'b0101, 4, te[4]), '1, "eof stamp");
    idv = {3'b001, 29'($random(seed))};
    wr(ma(3, ACCEPT_MASK_OFS), 32'h3FFFFFFF);
    wr(ma(3, IDENTIFIER_OFS), idv);
    wr(ma(3, MODE_OFS), 32'h02000000);
    fr(1'b1, idv[28:0], 1'b1, 5);
    fr(1'b1, idv[28:0] ^ 29'h1, 1'b0, 6);
    fr(1'b0, idv[28:0], 1'b0, 6);
    fr(1'b1, idv[28:0], 1'b0, 7);
    rd(ma(3, STATUS_OFS), st(4'b1100, 7, te[7]), '1, "overwrite");
    wr(ma(2, MODE_OFS), 32'h03000000);
    rd(ma(2, STATUS_OFS), st(4'b0100, 0, 16'h0), 32'hFFE00000, "tx mode");
    wr(ma(2, CONTROL_OFS), 32'h00800000);
    settle(2);
    rd(ma(2, STATUS_OFS), st(4'b0100, 0, 16'h0), 32'hFFE00000, "tx done");
    i_core.dly = 40;
    wr(ma(2, CONTROL_OFS), 32'h00800000);
    chk(32'(txr[2]), 32'h1, 32'h1, "tx request");
    wr(ma(2, CONTROL_OFS), 32'h00400000);
    rd(ma(2, STATUS_OFS), st(4'b0010, 0, 16'h0), 32'hFFE00000, "abort");
    chk(32'(txr[2]), 32'h0, 32'h1, "tx cancel");
    i_core.dly = 3;
    wr(ma(4, ACCEPT_MASK_OFS), 32'h1FFC0000);
    wr(ma(4, IDENTIFIER_OFS), 32'h01540000);
    wr(ma(4, MODE_OFS), 32'h04000000);
    rd(ma(4, STATUS_OFS), st(4'b0001, 0, 16'h0), 32'hFFF00000, "consumer");
    fr(1'b0, {11'h055, 18'h0}, 1'b0, 1);
    wr(ma(4, CONTROL_OFS), 32'h00800000);
    chk(32'(txo[4]), 32'h1, 32'h1, "remote out");
    settle(4);
    fr(1'b0, {11'h055, 18'h1}, 1'b0, 2);
    rd(ma(4, STATUS_OFS), st(4'b0100, 2, te[2]), 32'hFEEFFFFF, "answer");
    wr(ma(5, ACCEPT_MASK_OFS), 32'h1FFC0000);
    wr(ma(5, IDENTIFIER_OFS), 32'h03C00000);
    wr(ma(5, MODE_OFS), 32'h05000000);
    rd(ma(5, STATUS_OFS), st(4'b0100, 0, 16'h0), 32'hFFF00000, "producer");
    wr(ma(5, CONTROL_OFS), {8'h00, 4'h8, dl[3], 16'h0000});
    chk(32'(txr[5]), 32'h0, 32'h1, "producer waits");
    fr(1'b0, {11'h0F0, 18'h0}, 1'b1, 0);
    settle(5);
    rd(ma(5, STATUS_OFS), st(4'b0100, 3, 16'h0), 32'hFFEF0000, "produced");
    for (int i = 0; i < NUM_MB; i++) begin
      if (i != 5) chk(32'(n_store[i]), 32'(exp_store[i]), '1, "stores");
      chk(32'(n_irq[i]), 32'(exp_irq[i]), '1, "ready irq");
    end
    test_done();
  end
endmodule : tb_can_mailbox_filter_status
`default_nettype wire
